// >>> iocs_top.sv
// Refresh control and peripheral chip select configuration block.
// Assumes the processor I/O bus is on clk; the power-down refresh
// tick and the full power-down level come from outside and are
// synchronised here before use.

// Functional notes
// - Main slow-refresh bit slows main refresh
// - Bit 14 slows video refresh by eight
// - Power down: main refresh every eighth tick if main slow bit set, no video refresh
// - Bit 13 selects CAS-first refresh
// - Bit 12 holds CAS low in suspend
// - Bit 11 enables disk controller select 353X
// - Bits 10:9 place printer port window
// - Printer select asserted on window hit
// - Bit 8 picks printer port data path
// - Bits 7:5 place serial port A
// - Serial A select on window hit
// - Bit 4 picks serial A data path
// - Bits 3:1 place serial port B
// - Bit 0 picks serial B data path
// - Bit 15 picks real-time clock data path
// - Fast display I/O uses one wait
// - Disk controller waits: one or four
// - Bit 12 enables programmable select
// - Bit 11 compares upper address bits
// - Bits 10:8 set low-bit ignore count
// - Ignore encoding zero to four bits
// - Bit 7 picks programmable select path
module iocs_top #(
  parameter int SLOW_RATIO = 8
) (
  input  wire logic               clk,
  input  wire logic               nrst,
  input  wire iocs_pkg::iocs_iobus_t io,
  input  wire logic               slow_refresh_tick,
  input  wire logic               full_powerdown_select,
  input  wire logic               suspend,
  input  wire logic               normal_refresh_tick,
  output logic [15:0]             rdata,
  output logic                    rdata_valid,
  output iocs_pkg::iocs_select_t  sel,
  output logic                    main_refresh_req,
  output logic                    video_refresh_req,
  output logic                    cas_first_refresh_select,
  output logic                    cas_hold_low
);

  typedef struct packed {
    iocs_pkg::iocs_refsel_t refsel;
    iocs_pkg::iocs_clkpcs_t clkpcs;
    logic [15:0]            pcs_addr;
    logic [1:0]             tick_sync;
    logic                   tick_prev;
    logic [1:0]             fpd_sync;
    logic [1:0]             susp_sync;
    logic [1:0]             ntick_sync;
    logic                   ntick_prev;
    logic [2:0]             pd_count;
    logic [2:0]             main_div;
    logic [2:0]             video_div;
    logic [15:0]            rdata;
    logic                   rdata_valid;
    iocs_pkg::iocs_select_t sel;
    logic                   main_req;
    logic                   video_req;
    logic                   cbr;
    logic                   cas_hold;
  } iocs_state_t;

  iocs_state_t st;
  iocs_state_t next_st;
  logic        uart_a_hit;
  logic        uart_b_hit;

  // Last divider count; the dividers are three bits, so eight at most
  localparam logic [2:0] SLOW_LAST = 3'(SLOW_RATIO - 1);

  // Shared serial window decode for both ports
  iocs_decode u_dec_a (
    .window (st.refsel.uart_a_window),
    .addr   (io.addr[9:0]),
    .hit    (uart_a_hit)
  );
  iocs_decode u_dec_b (
    .window (st.refsel.uart_b_window),
    .addr   (io.addr[9:0]),
    .hit    (uart_b_hit)
  );

  // Next-state logic for registers, decode and refresh pacing
  always_comb begin
    logic       tick_edge;
    logic       ntick_edge;
    logic       pdown;
    logic       par_hit;
    logic       pcs_hit;
    logic [3:0] low_mask;
    logic       disk_hit;
    logic       disp_hit;
    tick_edge  = 1'b0;
    ntick_edge = 1'b0;
    pdown      = 1'b0;
    par_hit    = 1'b0;
    pcs_hit    = 1'b0;
    low_mask   = 4'hF;
    disk_hit   = 1'b0;
    disp_hit   = 1'b0;
    next_st    = st;

    // Two-flop synchronisers; only stage 1 is read by logic
    next_st.tick_sync  = {st.tick_sync[0], slow_refresh_tick};
    next_st.fpd_sync   = {st.fpd_sync[0], full_powerdown_select};
    next_st.susp_sync  = {st.susp_sync[0], suspend};
    next_st.ntick_sync = {st.ntick_sync[0], normal_refresh_tick};
    next_st.tick_prev  = st.tick_sync[1];
    next_st.ntick_prev = st.ntick_sync[1];
    tick_edge  = st.tick_sync[1] & ~st.tick_prev;
    ntick_edge = st.ntick_sync[1] & ~st.ntick_prev;
    pdown      = st.fpd_sync[1];

    // Register writes; read data returns stored value
    next_st.rdata_valid = 1'b0;
    if (io.io_cycle && io.wr) begin
      case (io.addr)
        iocs_pkg::REFSEL_ADDR: next_st.refsel = io.wdata;
        iocs_pkg::CLKPCS_ADDR: next_st.clkpcs = io.wdata;
        iocs_pkg::PCS_ADDR:    next_st.pcs_addr = io.wdata;
        default: ;
      endcase
    end
    if (io.io_cycle && io.rd) begin
      case (io.addr)
        iocs_pkg::REFSEL_ADDR: begin
          next_st.rdata       = st.refsel;
          next_st.rdata_valid = 1'b1;
        end
        iocs_pkg::CLKPCS_ADDR: begin
          next_st.rdata       = st.clkpcs;
          next_st.rdata_valid = 1'b1;
        end
        iocs_pkg::PCS_ADDR: begin
          next_st.rdata       = st.pcs_addr;
          next_st.rdata_valid = 1'b1;
        end
        default: next_st.rdata = iocs_pkg::REG_RESET;
      endcase
    end

    // Printer port window decode
    case (st.refsel.printer_port_window)
      2'h1: par_hit = (io.addr[9:2] == iocs_pkg::WIN_3BC[9:2]);
      2'h2: par_hit = (io.addr[9:3] == iocs_pkg::WIN_378[9:3]);
      2'h3: par_hit = (io.addr[9:3] == iocs_pkg::WIN_278[9:3]);
      default: par_hit = 1'b0;
    endcase

    // Programmable select: low bits ignored per mask code
    case (st.clkpcs.lower_addr_ignore)
      3'h0: low_mask = 4'hF;
      3'h1: low_mask = 4'hE;
      3'h2: low_mask = 4'hC;
      3'h3: low_mask = 4'h8;
      3'h4: low_mask = 4'h0;
      default: low_mask = 4'hF;
    endcase
    pcs_hit = (io.addr[9:4] == st.pcs_addr[9:4]) &&
              (((io.addr[3:0] ^ st.pcs_addr[3:0]) & low_mask) == 4'h0);
    if (st.clkpcs.upper_addr_compare) begin
      pcs_hit = pcs_hit && (io.addr[15:10] == st.pcs_addr[15:10]);
    end

    disk_hit = (io.addr[15:4] == iocs_pkg::WIN_353);
    disp_hit = (io.addr[9:4] == iocs_pkg::WIN_3C0[9:4]);

    // Selects are live only in an I/O cycle that hits
    next_st.sel.cs_disk_ctrl = io.io_cycle && disk_hit &&
                               st.refsel.disk_ctrl_select_en;
    next_st.sel.cs_printer   = io.io_cycle && par_hit;
    next_st.sel.cs_uart_a    = io.io_cycle && uart_a_hit;
    next_st.sel.cs_uart_b    = io.io_cycle && uart_b_hit;
    next_st.sel.cs_prog      = io.io_cycle && pcs_hit &&
                               st.clkpcs.prog_select_enable;

    // Data path of the selected peripheral
    next_st.sel.expansion_path = 1'b0;
    if (io.io_cycle) begin
      if (par_hit) begin
        next_st.sel.expansion_path = st.refsel.printer_port_bus_side;
      end else if (uart_a_hit) begin
        next_st.sel.expansion_path = st.refsel.uart_a_bus_side;
      end else if (uart_b_hit) begin
        next_st.sel.expansion_path = st.refsel.uart_b_bus_side;
      end else if (pcs_hit && st.clkpcs.prog_select_enable) begin
        next_st.sel.expansion_path =
          st.clkpcs.prog_select_bus_side;
      end else if (io.addr[9:1] == iocs_pkg::WIN_RTC[9:1]) begin
        next_st.sel.expansion_path = st.clkpcs.rtc_bus_side;
      end
    end

    // Wait states for display and disk controller cycles
    next_st.sel.wait_states = 3'h0;
    if (io.io_cycle && disp_hit && st.clkpcs.fast_display_io) begin
      next_st.sel.wait_states = iocs_pkg::WS_ONE;
    end else if (next_st.sel.cs_disk_ctrl) begin
      next_st.sel.wait_states = st.clkpcs.fast_disk_controller_io ?
        iocs_pkg::WS_ONE : iocs_pkg::WS_FOUR;
    end

    // Refresh pacing: normal tick, slow divides by eight
    next_st.main_req  = 1'b0;
    next_st.video_req = 1'b0;
    if (pdown) begin
      if (tick_edge && st.refsel.main_slow_refresh) begin
        next_st.pd_count = st.pd_count + 3'h1;
        next_st.main_req = (st.pd_count == SLOW_LAST);
      end
    end else if (ntick_edge) begin
      next_st.main_div  = st.main_div + 3'h1;
      next_st.video_div = st.video_div + 3'h1;
      next_st.main_req  = !st.refsel.main_slow_refresh ||
                          (st.main_div == SLOW_LAST);
      next_st.video_req = !st.refsel.video_slow_refresh ||
                          (st.video_div == SLOW_LAST);
    end

    next_st.cbr      = st.refsel.cas_first_refresh_select;
    next_st.cas_hold = st.refsel.self_refresh_in_suspend &&
                       st.susp_sync[1];
  end

  // State register with synchronous reset
  always_ff @(posedge clk) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  // Outputs straight from flip-flops
  assign rdata                    = st.rdata;
  assign rdata_valid              = st.rdata_valid;
  assign sel                      = st.sel;
  assign main_refresh_req         = st.main_req;
  assign video_refresh_req        = st.video_req;
  assign cas_first_refresh_select = st.cbr;
  assign cas_hold_low             = st.cas_hold;

  // Disk select never asserts while disabled
  a_disk_sel_gate: assert property (@(posedge clk) disable iff (!nrst)
    (!st.refsel.disk_ctrl_select_en ##1 !st.refsel.disk_ctrl_select_en)
      |-> !st.sel.cs_disk_ctrl)
    else $error("disk select while disabled");

  // Programmable select gated by enable
  a_prog_sel_gate: assert property (@(posedge clk) disable iff (!nrst)
    $past(!st.clkpcs.prog_select_enable) |-> !st.sel.cs_prog)
    else $error("programmable select while disabled");

  // Printer select only after an I/O cycle
  a_printer_cycle: assert property (@(posedge clk) disable iff (!nrst)
    st.sel.cs_printer |-> $past(io.io_cycle))
    else $error("printer select outside io cycle");

  // Disabled printer window yields no select
  a_printer_off: assert property (@(posedge clk) disable iff (!nrst)
    $past(st.refsel.printer_port_window == 2'h0) |-> !st.sel.cs_printer)
    else $error("printer select with window off");

  // Disk waits are four when the fast bit is clear
  a_disk_waits: assert property (@(posedge clk) disable iff (!nrst)
    (st.sel.cs_disk_ctrl && $past(!st.clkpcs.fast_disk_controller_io)
     && !$past(st.clkpcs.fast_display_io))
      |-> st.sel.wait_states == 3'h4)
    else $error("disk controller wait count wrong");

  // Register write is stored in the refresh register
  a_reg_readback: assert property (@(posedge clk) disable iff (!nrst)
    (io.io_cycle && io.wr && !io.rd && io.addr == iocs_pkg::REFSEL_ADDR)
      |=> st.refsel == $past(io.wdata))
    else $error("refresh register did not store write");

  // Serial A off means no select
  a_uart_a_off: assert property (@(posedge clk) disable iff (!nrst)
    $past(st.refsel.uart_a_window == 3'h0) |-> !st.sel.cs_uart_a)
    else $error("serial A select with window off");

  // CAS hold needs self refresh bit
  a_cas_hold: assert property (@(posedge clk) disable iff (!nrst)
    st.cas_hold |-> $past(st.refsel.self_refresh_in_suspend))
    else $error("CAS held low without self refresh");

  // Serial B off means no select
  a_uart_b_off: assert property (@(posedge clk) disable iff (!nrst)
    $past(st.refsel.uart_b_window == 3'h0) |-> !st.sel.cs_uart_b)
    else $error("serial B select with window off");

  // Fast display cycles take one wait
  a_disp_waits: assert property (@(posedge clk) disable iff (!nrst)
    ($past(io.io_cycle && st.clkpcs.fast_display_io) &&
     $past(io.addr[9:4] == iocs_pkg::WIN_3C0[9:4]))
      |-> st.sel.wait_states == iocs_pkg::WS_ONE)
    else $error("display wait count wrong");

  // Second register write is stored in the control register
  a_ctrl_readback: assert property (@(posedge clk) disable iff (!nrst)
    (io.io_cycle && io.wr && !io.rd && io.addr == iocs_pkg::CLKPCS_ADDR)
      |=> st.clkpcs == $past(io.wdata))
    else $error("control register did not store write");

  // Refresh method output mirrors its bit
  a_cbr_copy: assert property (@(posedge clk) disable iff (!nrst)
    st.cbr == $past(st.refsel.cas_first_refresh_select))
    else $error("refresh method output stale");

  // Video requests are single-cycle pulses
  a_video_pulse: assert property (@(posedge clk) disable iff (!nrst)
    st.video_req |=> !st.video_req)
    else $error("video refresh request longer than a cycle");

  // No video refresh request in full power down
  a_video_pdown: assert property (@(posedge clk) disable iff (!nrst)
    $past(st.fpd_sync[1]) |-> !st.video_req)
    else $error("video refresh in power down");

  // Power down without slow bit gives no main refresh
  a_main_pdown: assert property (@(posedge clk) disable iff (!nrst)
    $past(st.fpd_sync[1] && !st.refsel.main_slow_refresh)
      |-> !st.main_req)
    else $error("main refresh in power down without slow bit");

  // Disk select only after an I/O cycle
  a_disk_cycle: assert property (@(posedge clk) disable iff (!nrst)
    st.sel.cs_disk_ctrl |-> $past(io.io_cycle))
    else $error("disk select outside io cycle");

  // Programmable select only after an I/O cycle
  a_prog_cycle: assert property (@(posedge clk) disable iff (!nrst)
    st.sel.cs_prog |-> $past(io.io_cycle))
    else $error("programmable select outside io cycle");

  // CAS hold needs the suspend level
  a_cas_suspend: assert property (@(posedge clk) disable iff (!nrst)
    st.cas_hold |-> $past(st.susp_sync[1]))
    else $error("CAS held low outside suspend");

  // Read data valid only after a read
  a_read_valid: assert property (@(posedge clk) disable iff (!nrst)
    st.rdata_valid |-> $past(io.io_cycle && io.rd))
    else $error("read valid without a read");

endmodule

// >>> iocs_pkg.sv
// Package for the I/O chip select and refresh configuration block.
// Assumes a single 25 MHz clock domain and a 16-bit processor I/O bus.
package iocs_pkg;

  // Register port addresses
  localparam logic [15:0] REFSEL_ADDR = 16'h2072;
  localparam logic [15:0] CLKPCS_ADDR = 16'h2872;
  localparam logic [15:0] PCS_ADDR    = 16'h3072;
  localparam logic [15:0] REG_RESET   = 16'h0000;

  // Fixed decode windows (10-bit, upper bits ignored; WIN_353 is 12-bit against addr[15:4])
  localparam logic [9:0] WIN_3BC   = 10'h3BC;
  localparam logic [9:0] WIN_378   = 10'h378;
  localparam logic [9:0] WIN_278   = 10'h278;
  localparam logic [9:0] WIN_3F8   = 10'h3F8;
  localparam logic [9:0] WIN_2F8   = 10'h2F8;
  localparam logic [9:0] WIN_3E8   = 10'h3E8;
  localparam logic [9:0] WIN_2E8   = 10'h2E8;
  localparam logic [9:0] WIN_3C0   = 10'h3C0;
  localparam logic [9:0] WIN_RTC   = 10'h070;
  localparam logic [11:0] WIN_353  = 12'h353;
  localparam logic [2:0] SLOW_DIV  = 3'h7;

  // Wait-state counts
  localparam logic [2:0] WS_ONE  = 3'h1;
  localparam logic [2:0] WS_FOUR = 3'h4;

  // Register layouts
  typedef struct packed {
    logic       main_slow_refresh;
    logic       video_slow_refresh;
    logic       cas_first_refresh_select;
    logic       self_refresh_in_suspend;
    logic       disk_ctrl_select_en;
    logic [1:0] printer_port_window;
    logic       printer_port_bus_side;
    logic [2:0] uart_a_window;
    logic       uart_a_bus_side;
    logic [2:0] uart_b_window;
    logic       uart_b_bus_side;
  } iocs_refsel_t;

  typedef struct packed {
    logic       rtc_bus_side;
    logic       fast_display_io;
    logic       fast_disk_controller_io;
    logic       prog_select_enable;
    logic       upper_addr_compare;
    logic [2:0] lower_addr_ignore;
    logic       prog_select_bus_side;
    logic [6:0] other_bits;
  } iocs_clkpcs_t;

  // I/O bus request from the processor
  typedef struct packed {
    logic        io_cycle;
    logic        wr;
    logic        rd;
    logic [15:0] addr;
    logic [15:0] wdata;
  } iocs_iobus_t;

  // Chip select outputs
  typedef struct packed {
    logic cs_disk_ctrl;
    logic cs_printer;
    logic cs_uart_a;
    logic cs_uart_b;
    logic cs_prog;
    logic expansion_path;
    logic [2:0] wait_states;
  } iocs_select_t;

endpackage

// >>> iocs_decode.sv
// Serial port window decoder, shared by both serial chip selects.
// Assumes a combinational use inside the clocked main block.
module iocs_decode (
  input  wire logic [2:0] window,
  input  wire logic [9:0] addr,
  output logic            hit
);
  logic [9:0] base;

  // Window base from the three-bit placement code
  always_comb begin
    base = iocs_pkg::WIN_3F8;
    hit  = 1'b0;
    case (window)
      3'h1: base = iocs_pkg::WIN_3F8;
      3'h2: base = iocs_pkg::WIN_2F8;
      3'h3: base = iocs_pkg::WIN_3E8;
      3'h4: base = iocs_pkg::WIN_2E8;
      default: base = iocs_pkg::WIN_3F8;
    endcase
    // Codes 0 and 5..7 select nothing
    if (window >= 3'h1 && window <= 3'h4) begin
      hit = (addr[9:3] == base[9:3]);
    end
  end
endmodule

// >>> iocs_host_model.sv
// Host processor I/O bus model: single-cycle requests, read capture.
// Assumes the block samples io on each rising clk edge.
module iocs_host_model (
  input  wire logic             clk,
  input  wire logic [15:0]      rdata,
  input  wire logic             rdata_valid,
  output iocs_pkg::iocs_iobus_t io
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] last_rd;
  logic        last_vld;
  initial io = '0;
  // One cycle of request; released address and data show inverted values so a
  // stale address can never look like a held one
  task automatic cycle(input logic c, input logic w, input logic r,
                       input logic [15:0] a, input logic [15:0] d);
    @(posedge clk);
    io <= '{io_cycle: c, wr: w, rd: r, addr: a, wdata: d};
    @(posedge clk);
    io <= '{io_cycle: 1'b0, wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    @(posedge clk);
    last_rd = rdata;
    last_vld = rdata_valid;
  endtask
endmodule

// >>> iocs_top_tb_top.sv
// Self-checking bench for the I/O select and refresh block.
// Assumes the host model owns io; the bench drives ticks and levels.
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin \
  err_count++; $display("[FAIL] %0t got %h exp %h", $time, g, e); end end
module iocs_top_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [15:0] A0 = iocs_pkg::REFSEL_ADDR;
  localparam logic [15:0] A1 = iocs_pkg::CLKPCS_ADDR;
  localparam logic [15:0] A2 = iocs_pkg::PCS_ADDR;
  logic                   clk, nrst, stick, pdn, susp, ntick;
  logic                   rvld, mreq, vreq, cfs, cas;
  logic [15:0]            rdata, r0, r1, r2;
  iocs_pkg::iocs_iobus_t  io;
  iocs_pkg::iocs_select_t sel;
  int                     err_count, cmp_count, cyc, nm, nv, i, j;
  logic [15:0]            exp_q [$];
  logic [6:0]             ubase [5] = '{7'h00, 7'h7F, 7'h5F, 7'h7D, 7'h5D};
  logic [9:0]             base [9] = '{10'h3F8, 10'h2F8, 10'h3E8, 10'h2E8,
                                       10'h3BC, 10'h378, 10'h278, 10'h3C0,
                                       10'h070};

  iocs_host_model host_u (.clk(clk), .rdata(rdata), .rdata_valid(rvld),
                          .io(io));
  iocs_top #(.SLOW_RATIO(8)) dut_u (
    .clk(clk), .nrst(nrst), .io(io), .slow_refresh_tick(stick),
    .full_powerdown_select(pdn), .suspend(susp),
    .normal_refresh_tick(ntick), .rdata(rdata), .rdata_valid(rvld),
    .sel(sel), .main_refresh_req(mreq), .video_refresh_req(vreq),
    .cas_first_refresh_select(cfs), .cas_hold_low(cas));

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  // Pulse counting and hang guard
  always @(posedge clk) begin
    cyc++;
    if (mreq === 1'b1) nm++;
    if (vreq === 1'b1) nv++;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  task automatic conclude();
    $display("errors %0d compares %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic do_reset();
    @(posedge clk) nrst <= 1'b0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    r0 = '0;
    r1 = '0;
    r2 = '0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    host_u.cycle(1'b1, 1'b1, 1'b0, a, d);
    if (a == A0) r0 = d;
    if (a == A1) r1 = d;
    if (a == A2) r2 = d;
  endtask

  task automatic rd_chk(input logic [15:0] a);
    logic        m;
    logic [15:0] e;
    m = a == A0 || a == A1 || a == A2;
    if (m) exp_q.push_back(a == A0 ? r0 : a == A1 ? r1 : r2);
    host_u.cycle(1'b1, 1'b0, 1'b1, a, 16'h0000);
    `CHK(host_u.last_vld, m)
    if (m) begin
      e = exp_q.pop_front();
      `CHK(host_u.last_rd, e)
    end
  endtask

  // Reference decode: {disk, printer, uart a, uart b, programmable}
  function automatic logic [4:0] exp_cs(input logic [15:0] a);
    logic [9:0] m;
    m = 10'h3FF << r1[10:8];
    exp_cs[4] = r0[11] && a[15:4] == 12'h353;
    exp_cs[3] = (r0[10:9] == 2'h1 && a[9:2] == 8'hEF) ||
                (r0[10:9] == 2'h2 && a[9:3] == 7'h6F) ||
                (r0[10:9] == 2'h3 && a[9:3] == 7'h4F);
    exp_cs[2] = r0[7:5] != 0 && r0[7:5] < 5 && a[9:3] == ubase[r0[7:5]];
    exp_cs[1] = r0[3:1] != 0 && r0[3:1] < 5 && a[9:3] == ubase[r0[3:1]];
    exp_cs[0] = r1[12] && ((a[9:0] ^ r2[9:0]) & m) == 0 &&
                (!r1[11] || a[15:10] == r2[15:10]);
  endfunction

  task automatic sel_op(input logic c, input logic [15:0] a);
    logic [4:0] h;
    logic       rt, ep;
    h = c ? exp_cs(a) : 5'h00;
    rt = c && a[9:1] == 9'h038;
    ep = h[3] ? r0[8] : h[2] ? r0[4] : h[1] ? r0[0] : h[0] ? r1[7] : r1[15];
    host_u.cycle(c, 1'b0, 1'b0, a, 16'h0000);
    `CHK(sel.cs_disk_ctrl, h[4])
    `CHK(sel.cs_printer, h[3])
    `CHK(sel.cs_uart_a, h[2])
    `CHK(sel.cs_uart_b, h[1])
    `CHK(sel.cs_prog, h[0])
    if (!h[4] && $countones({h[3:0], rt}) == 1)
      `CHK(sel.expansion_path, ep)
    if (h[4])
      `CHK(sel.wait_states, r1[13] ? iocs_pkg::WS_ONE : 3'h4)
    else if (c && a[9:4] == 6'h3C)
      `CHK(sel.wait_states, r1[14] ? iocs_pkg::WS_ONE : 3'h0)
  endtask

  // Addresses aimed at every window, with random upper bits on the fixed 10-bit windows
  function automatic logic [15:0] pick();
    logic [15:0] a;
    int          k;
    a = 16'($urandom);
    k = $urandom % 11;
    if (k < 9) a[9:0] = base[k] + 10'($urandom % 8);
    else if (k == 9) a = r2 ^ 16'($urandom % 16);
    else a = 16'h3530 + 16'($urandom % 16);
    return a;
  endfunction

  task automatic cfg();
    logic [15:0] v;
    logic [2:0]  ua, ub;
    ua = 3'($urandom % 5);
    ub = 3'($urandom % 5);
    if (ua == ub) ub = 3'h0;
    v = 16'($urandom);
    v[7:5] = ua;
    v[3:1] = ub;
    wr(A0, v);
    v = 16'($urandom);
    v[10:8] = 3'($urandom % 5);
    wr(A1, v);
    wr(A2, 16'($urandom));
    for (int n = 0; n < 3; n++) rd_chk(A0 + 16'(n) * 16'h0800);
  endtask

  // Ticks spaced six cycles apart, well over the minimum
  task automatic tick(input logic slow);
    @(posedge clk);
    if (slow) stick <= 1'b1;
    else ntick <= 1'b1;
    repeat (3) @(posedge clk);
    stick <= 1'b0;
    ntick <= 1'b0;
    repeat (2) @(posedge clk);
  endtask

  // Sixteen ticks hold exactly two eighths whatever the divider phase
  task automatic ref_chk(input logic slow, input int em, input int ev);
    nm = 0;
    nv = 0;
    repeat (16) tick(slow);
    repeat (8) @(posedge clk);
    `CHK(nm, em)
    if (ev >= 0) `CHK(nv, ev)
  endtask

  initial begin
    nrst = 1'b0;
    stick = 1'b0;
    pdn = 1'b0;
    susp = 1'b0;
    ntick = 1'b0;
    void'($urandom(9130));
    do_reset();
    for (j = 0; j < 3; j++) rd_chk(A0 + 16'(j) * 16'h0800);
    wr(16'h4072, 16'hFFFF);
    rd_chk(16'h4072);
    rd_chk(A0);
    ref_chk(1'b0, 16, 16);
    wr(A0, 16'hC000);
    ref_chk(1'b0, 2, 2);
    pdn <= 1'b1;
    ref_chk(1'b1, 2, -1);
    ref_chk(1'b0, 0, -1);
    wr(A0, 16'h0000);
    ref_chk(1'b1, 0, -1);
    pdn <= 1'b0;
    wr(A0, 16'h3000);
    repeat (6) @(posedge clk);
    `CHK(cfs, 1'b1)
    `CHK(cas, 1'b0)
    susp <= 1'b1;
    repeat (6) @(posedge clk);
    `CHK(cas, 1'b1)
    wr(A0, 16'h2000);
    // Hold output drops one edge after the cleared bit lands
    @(posedge clk);
    `CHK(cas, 1'b0)
    susp <= 1'b0;
    for (i = 0; i < 40; i++) begin
      cfg();
      for (j = 0; j < 8; j++) sel_op($urandom % 4 != 0, pick());
    end
    do_reset();
    for (j = 0; j < 3; j++) rd_chk(A0 + 16'(j) * 16'h0800);
    sel_op(1'b1, 16'h03F8);
    conclude();
  end
endmodule
